//--- verilog/slfc_pkg.sv
// Constants and types shared by the link frame checker
package slfc_pkg;
  // ==========================================================
  // Character classes
  typedef enum logic [3:0] {
    SLFC_CH_DATA, SLFC_CH_FLAG, SLFC_CH_ABORT, SLFC_CH_ACK, SLFC_CH_RRDY,
    SLFC_CH_NUL, SLFC_CH_USER, SLFC_CH_FAIR, SLFC_CH_FAIRR, SLFC_CH_OTHER
  } slfc_char_e;
  // ==========================================================
  // Port states and modes
  typedef enum logic [1:0] {SLFC_ST_DISABLED, SLFC_ST_ENABLED, SLFC_ST_READY, SLFC_ST_CHECK} slfc_state_e;
  typedef enum logic [1:0] {SLFC_MD_PRIV, SLFC_MD_NORMAL, SLFC_MD_OTHER} slfc_mode_e;
  // ==========================================================
  // Control byte layout
  localparam int SLFC_FT_HI = 3;
  localparam int SLFC_FT_LO = 2;
  localparam int SLFC_SEQ_HI = 1;
  localparam int SLFC_SEQ_LO = 0;
  localparam logic [3:0] SLFC_CTL_RSVD = 4'h0;
  localparam logic [1:0] SLFC_FT_APP = 2'h0;
  localparam logic [1:0] SLFC_FT_RSVD = 2'h1;
  localparam logic [1:0] SLFC_FT_CFG = 2'h2;
  localparam logic [1:0] SLFC_FT_CTRL = 2'h3;
  localparam logic [1:0] SLFC_RT_LINK = 2'h0;
  localparam logic [1:0] SLFC_RT_TOTAL = 2'h1;
  localparam logic [1:0] SLFC_RT_RSVD = 2'h2;
  localparam logic [1:0] SLFC_RT_ABS = 2'h3;
  localparam logic [1:0] SLFC_SEQ_RESET = 2'h0;
  // ==========================================================
  // Counts
  localparam int SLFC_MIN_FRAME = 6;
  localparam int SLFC_IDLE_FLAGS = 10;
  localparam logic [7:0] SLFC_HDR_LEN = 8'h05;
  // ==========================================================
  // Error causes
  typedef enum logic [1:0] {SLFC_ERR_NONE, SLFC_ERR_PROTO, SLFC_ERR_SEQ, SLFC_ERR_REJECT} slfc_err_e;
endpackage

//--- verilog/slfc_fifo.sv
// Synchronous valid/ready FIFO for received frame characters
`timescale 1ns/1ps
module slfc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in && (count != (AW+1)'(DEPTH));
  wire pop = out_ready_in && (count != '0);
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  a_fifo_bound: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // slfc_fifo

//--- verilog/slfc_checker.sv
// Link frame checker: sequence rules, control byte decode and frame sequence counters
`timescale 1ns/1ps
module slfc_checker import slfc_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] port_state_in,
  input wire logic [1:0] port_mode_in,
  input wire logic dest_here_in,
  input wire logic rx_valid_in,
  input wire logic [3:0] rx_class_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_data_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_first_out,
  input wire logic rx_data_ready_in,
  output logic rx_overflow_out,
  output logic rx_frame_good_out,
  output logic rx_frame_drop_out,
  output logic ack_req_out,
  output logic [1:0] rx_frame_type_out,
  output logic fwd_ok_out,
  output logic reset_link_out,
  output logic reset_total_out,
  output logic reset_abs_out,
  output logic erp_pulse_out,
  output logic [1:0] erp_cause_out,
  input wire logic [1:0] tx_frame_type_in,
  input wire logic tx_frame_req_in,
  output logic tx_frame_allow_out,
  input wire logic tx_trail_flag_in,
  input wire logic tx_abort_in,
  output logic [1:0] tx_seq_out,
  output logic [1:0] rx_seq_out,
  output logic [1:0] fwd_seq_out
);
  // ==========================================================
  // Receive character decode
  wire is_ready = (port_state_in == SLFC_ST_READY);
  wire is_check = (port_state_in == SLFC_ST_CHECK);
  wire is_disabled = (port_state_in == SLFC_ST_DISABLED);
  wire is_priv = (port_mode_in == SLFC_MD_PRIV);
  wire is_norm = (port_mode_in == SLFC_MD_NORMAL);
  wire c_data = rx_valid_in && (rx_class_in == SLFC_CH_DATA);
  wire c_flag = rx_valid_in && (rx_class_in == SLFC_CH_FLAG);
  wire c_abort = rx_valid_in && (rx_class_in == SLFC_CH_ABORT);
  wire c_ack = rx_valid_in && (rx_class_in == SLFC_CH_ACK);
  wire c_rrdy = rx_valid_in && (rx_class_in == SLFC_CH_RRDY);
  wire c_ins = rx_valid_in && (rx_class_in == SLFC_CH_USER || rx_class_in == SLFC_CH_FAIR ||
    rx_class_in == SLFC_CH_FAIRR);
  logic pend_ack;
  logic pend_rrdy;
  logic pend_abort;
  logic data_since_flag;
  logic in_frame;
  logic frame_bad;
  logic [3:0] idle_flags;
  logic [7:0] frame_len;
  logic [7:0] ctl_byte;
  logic [1:0] tx_seq;
  logic [1:0] rx_seq;
  // Broken pair: pending first half not followed by its mate
  wire brk_ack = pend_ack && rx_valid_in && !c_ack;
  wire brk_rrdy = pend_rrdy && rx_valid_in && !c_rrdy;
  wire brk_abort = pend_abort && rx_valid_in && !c_flag;
  wire abort_early = c_abort && !data_since_flag;
  wire pair_open = c_ack && !pend_ack || c_rrdy && !pend_rrdy;
  wire idle_ins = !in_frame && (is_ready || is_check) &&
    (idle_flags < 4'(SLFC_IDLE_FLAGS)) && (pair_open || c_ins);
  wire proto_err = is_ready && (brk_ack || brk_rrdy || brk_abort || abort_early || idle_ins);
  // ==========================================================
  // Frame end evaluation
  wire abort_end = c_flag && pend_abort;
  wire frame_end = c_flag && data_since_flag && !pend_abort;
  wire [1:0] ftype = ctl_byte[SLFC_FT_HI:SLFC_FT_LO];
  wire [1:0] fseq = ctl_byte[SLFC_SEQ_HI:SLFC_SEQ_LO];
  wire f_ctrl = (ftype == SLFC_FT_CTRL);
  wire f_app = (ftype == SLFC_FT_APP);
  wire short_frame = frame_len < 8'(SLFC_MIN_FRAME);
  wire rsvd_bad = dest_here_in && ((ftype == SLFC_FT_RSVD) ||
    (f_ctrl && fseq == SLFC_RT_RSVD) || (ctl_byte[7:4] != SLFC_CTL_RSVD));
  // Header-only length budget: control frames carry status/path plus CRC, no data
  wire ctrl_len_bad = f_ctrl && (frame_len > SLFC_HDR_LEN + 8'h04);
  wire seq_bad = !f_ctrl && (fseq != rx_seq);
  wire priv_app = is_priv && f_app;
  wire other_bad = frame_bad || short_frame || ctrl_len_bad;
  wire frame_ok = frame_end && !other_bad && !rsvd_bad && !seq_bad && !proto_err;
  logic [1:0] next_cause;
  always_comb begin
    next_cause = SLFC_ERR_NONE;
    if (proto_err || (frame_end && (short_frame || ctrl_len_bad))) begin
      next_cause = SLFC_ERR_PROTO;
    end else if (frame_end && !frame_bad && rsvd_bad) begin
      next_cause = SLFC_ERR_REJECT;
    end else if (frame_end && !frame_bad && seq_bad && !priv_app) begin
      next_cause = SLFC_ERR_SEQ;
    end
  end
  // ==========================================================
  // Receive framing state
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pend_ack <= 1'b0;
      pend_rrdy <= 1'b0;
      pend_abort <= 1'b0;
      data_since_flag <= 1'b0;
      in_frame <= 1'b0;
      frame_bad <= 1'b0;
      idle_flags <= '0;
      frame_len <= '0;
      ctl_byte <= '0;
    end else if (rx_valid_in) begin
      pend_ack <= c_ack && !pend_ack;
      pend_rrdy <= c_rrdy && !pend_rrdy;
      pend_abort <= c_abort;
      if (c_flag) begin
        data_since_flag <= 1'b0;
        in_frame <= 1'b0;
        frame_bad <= 1'b0;
        frame_len <= '0;
        if (!data_since_flag && idle_flags != 4'(SLFC_IDLE_FLAGS)) begin
          idle_flags <= idle_flags + 4'h1;
        end else if (data_since_flag) begin
          idle_flags <= 4'h1;
        end
      end else if (c_data) begin
        data_since_flag <= 1'b1;
        in_frame <= 1'b1;
        if (frame_len != 8'hff) begin
          frame_len <= frame_len + 8'h01;
        end
        if (!data_since_flag) begin
          ctl_byte <= rx_data_in;
        end
      end
      if (proto_err) begin
        frame_bad <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Sequence counters
  wire tx_adv = tx_trail_flag_in && !tx_abort_in && (tx_frame_type_in != SLFC_FT_CTRL);
  // Discarded application frames are treated as never received
  wire rx_adv = frame_ok && !f_ctrl && !priv_app;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in || is_disabled) begin
      tx_seq <= SLFC_SEQ_RESET;
      rx_seq <= SLFC_SEQ_RESET;
    end else begin
      if (tx_adv) begin
        tx_seq <= tx_seq + 2'h1;
      end
      if (rx_adv) begin
        rx_seq <= rx_seq + 2'h1;
      end
    end
  end
  // ==========================================================
  // Transmit permission
  wire allow_ctrl = (is_ready || is_check || port_state_in == SLFC_ST_ENABLED) && (is_priv || is_norm);
  wire allow_cfg = is_ready && (is_priv || is_norm);
  wire allow_app = is_ready && is_norm;
  wire next_allow = tx_frame_req_in && ((tx_frame_type_in == SLFC_FT_CTRL) ? allow_ctrl :
    (tx_frame_type_in == SLFC_FT_APP) ? allow_app : allow_cfg);
  // ==========================================================
  // Receive data path through FIFO
  wire fifo_in_ready;
  wire [8:0] fifo_out;
  wire fifo_out_valid;
  wire push_char = c_data && !(is_priv && !data_since_flag && rx_data_in[SLFC_FT_HI:SLFC_FT_LO] == SLFC_FT_APP);
  slfc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(push_char),
    .in_ready_out(fifo_in_ready),
    .in_data_in({!data_since_flag, rx_data_in}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(rx_data_ready_in || !rx_data_valid_out),
    .out_data_out(fifo_out)
  );
  wire fifo_take = fifo_out_valid && (rx_data_ready_in || !rx_data_valid_out);
  // Link cannot be stalled, so a full FIFO is reported rather than back-pressured
  wire overflow = push_char && !fifo_in_ready;
  // ==========================================================
  // Output registers
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rx_data_valid_out <= 1'b0;
      rx_data_out <= '0;
      rx_first_out <= 1'b0;
      rx_overflow_out <= 1'b0;
      rx_frame_good_out <= 1'b0;
      rx_frame_drop_out <= 1'b0;
      ack_req_out <= 1'b0;
      rx_frame_type_out <= '0;
      fwd_ok_out <= 1'b0;
      reset_link_out <= 1'b0;
      reset_total_out <= 1'b0;
      reset_abs_out <= 1'b0;
      erp_pulse_out <= 1'b0;
      erp_cause_out <= SLFC_ERR_NONE;
      tx_frame_allow_out <= 1'b0;
      tx_seq_out <= SLFC_SEQ_RESET;
      rx_seq_out <= SLFC_SEQ_RESET;
      fwd_seq_out <= SLFC_SEQ_RESET;
    end else begin
      if (fifo_take) begin
        rx_data_valid_out <= 1'b1;
        rx_data_out <= fifo_out[7:0];
        rx_first_out <= fifo_out[8];
      end else if (rx_data_ready_in) begin
        rx_data_valid_out <= 1'b0;
      end
      rx_overflow_out <= overflow;
      rx_frame_good_out <= frame_ok && !priv_app;
      rx_frame_drop_out <= abort_end && data_since_flag || frame_end && !frame_ok || frame_ok && priv_app;
      ack_req_out <= frame_ok && !f_ctrl && !priv_app;
      rx_frame_type_out <= ftype;
      fwd_ok_out <= frame_end && !other_bad && !proto_err && (f_ctrl || !seq_bad);
      reset_link_out <= frame_ok && f_ctrl && fseq == SLFC_RT_LINK;
      reset_total_out <= frame_ok && f_ctrl && (fseq == SLFC_RT_TOTAL || fseq == SLFC_RT_ABS);
      reset_abs_out <= frame_ok && f_ctrl && fseq == SLFC_RT_ABS;
      erp_pulse_out <= (next_cause != SLFC_ERR_NONE);
      erp_cause_out <= next_cause;
      tx_frame_allow_out <= next_allow;
      tx_seq_out <= tx_seq;
      rx_seq_out <= rx_seq;
      fwd_seq_out <= tx_seq;
    end
  end
  // ==========================================================
  // Checks
  a_pair_break: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    is_ready && pend_ack && rx_valid_in && !c_ack |=> erp_pulse_out && erp_cause_out == SLFC_ERR_PROTO)
    else $error("broken ack pair not flagged");
  a_abort_space: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    is_ready && c_abort && !data_since_flag |=> erp_pulse_out)
    else $error("early abort not flagged");
  a_proto_cause: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    proto_err |=> erp_cause_out == SLFC_ERR_PROTO)
    else $error("protocol cause wrong");
  a_short_frame: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    frame_end && short_frame |=> !rx_frame_good_out)
    else $error("short frame accepted");
  a_abort_noack: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    abort_end |=> !ack_req_out && $stable(rx_seq))
    else $error("aborted frame acted on");
  a_tx_adv: assert property (@(posedge sys_clk_in) disable iff (!nrst_in || is_disabled)
    tx_adv |=> tx_seq == $past(tx_seq) + 2'h1)
    else $error("transmit counter did not advance");
  a_tx_hold: assert property (@(posedge sys_clk_in) disable iff (!nrst_in || is_disabled)
    !tx_adv |=> $stable(tx_seq))
    else $error("transmit counter moved");
  a_seq_err: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    frame_end && !other_bad && !rsvd_bad && seq_bad && !proto_err && !priv_app |=>
    erp_cause_out == SLFC_ERR_SEQ && !ack_req_out)
    else $error("sequence error missed");
  a_app_priv: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    tx_frame_req_in && tx_frame_type_in == SLFC_FT_APP && is_priv |=> !tx_frame_allow_out)
    else $error("application allowed in privileged mode");
  a_disable_clr: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    is_disabled |=> tx_seq == SLFC_SEQ_RESET && rx_seq == SLFC_SEQ_RESET)
    else $error("counters not cleared");
  c_good_frame: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) rx_frame_good_out);
  c_seq_error: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) erp_cause_out == SLFC_ERR_SEQ);
  c_abort_frame: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) abort_end && data_since_flag);
  c_total_reset: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) reset_total_out);
endmodule // slfc_checker

//--- tb/slfc_peer.sv
// Peer port model: sends characters and whole frames toward the checker
`timescale 1ns/1ps
module slfc_peer import slfc_pkg::*; (
  input wire logic sys_clk_in,
  output logic valid_out,
  output logic [3:0] class_out,
  output logic [7:0] data_out
);
  // ==========================================================
  // Character drive
  initial begin
    valid_out = 1'b0;
    class_out = SLFC_CH_FLAG;
    data_out = 8'h00;
  end
  task automatic put(input logic [3:0] cls, input logic [7:0] dat);
    @(posedge sys_clk_in);
    #1;
    valid_out = 1'b1;
    class_out = cls;
    data_out = dat;
  endtask
  // Idle bus shows inverted data so a stale byte never looks fresh
  task automatic idle();
    @(posedge sys_clk_in);
    #1;
    valid_out = 1'b0;
    data_out = ~data_out;
  endtask
  // ==========================================================
  // Frame: optional leading flag, control byte, filler, optional abort pair
  task automatic frame(input logic [7:0] ctl, input int len, input logic ab, input logic lead);
    if (lead) put(SLFC_CH_FLAG, 8'h00);
    put(SLFC_CH_DATA, ctl);
    for (int i = 1; i < len; i++) put(SLFC_CH_DATA, 8'h40 + i[7:0]);
    if (ab) put(SLFC_CH_ABORT, 8'h00);
    put(SLFC_CH_FLAG, 8'h00);
  endtask
endmodule // slfc_peer

//--- tb/tb.sv
// Testbench for the link frame checker with a peer port model
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module tb import slfc_pkg::*; ();
  // ==========================================================
  // Signals and event counters
  localparam int GD = 0, DR = 1, AK = 2, ER = 3, FW = 4, RL = 5, RT = 6, RA = 7, OV = 8, WD = 9;
  logic sys_clk_in, nrst_in, dest_here_in, rx_valid_in, rx_data_ready_in, tx_frame_req_in, tx_trail_flag_in;
  logic tx_abort_in, rx_data_valid_out, rx_first_out, rx_overflow_out, rx_frame_good_out, rx_frame_drop_out;
  logic ack_req_out, fwd_ok_out, reset_link_out, reset_total_out, reset_abs_out, erp_pulse_out, tx_frame_allow_out;
  logic [1:0] port_state_in, port_mode_in, tx_frame_type_in, rx_frame_type_out, erp_cause_out, tx_seq_out;
  logic [1:0] rx_seq_out, fwd_seq_out, cause, rxs;
  logic [3:0] rx_class_in;
  logic [7:0] rx_data_in, rx_data_out, first_byte;
  int err_total = 0, checked = 0;
  int cnt [10];
  slfc_checker #(.FIFO_DEPTH(16)) slfc_checker_inst (.sys_clk_in, .nrst_in, .port_state_in, .port_mode_in,
    .dest_here_in, .rx_valid_in, .rx_class_in, .rx_data_in, .rx_data_valid_out, .rx_data_out, .rx_first_out,
    .rx_data_ready_in, .rx_overflow_out, .rx_frame_good_out, .rx_frame_drop_out, .ack_req_out,
    .rx_frame_type_out, .fwd_ok_out, .reset_link_out, .reset_total_out, .reset_abs_out, .erp_pulse_out,
    .erp_cause_out, .tx_frame_type_in, .tx_frame_req_in, .tx_frame_allow_out, .tx_trail_flag_in, .tx_abort_in,
    .tx_seq_out, .rx_seq_out, .fwd_seq_out);
  slfc_peer slfc_peer_inst (.sys_clk_in, .valid_out(rx_valid_in), .class_out(rx_class_in), .data_out(rx_data_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  // Pulses are counted, so a doubled or missing pulse shows as a wrong count
  always @(posedge sys_clk_in) begin
    cnt[GD] += int'(rx_frame_good_out === 1'b1);
    cnt[DR] += int'(rx_frame_drop_out === 1'b1);
    cnt[AK] += int'(ack_req_out === 1'b1);
    cnt[FW] += int'(fwd_ok_out === 1'b1);
    cnt[RL] += int'(reset_link_out === 1'b1);
    cnt[RT] += int'(reset_total_out === 1'b1);
    cnt[RA] += int'(reset_abs_out === 1'b1);
    cnt[OV] += int'(rx_overflow_out === 1'b1);
    if (erp_pulse_out === 1'b1) begin
      cnt[ER]++;
      cause = erp_cause_out;
    end
    if (rx_data_valid_out === 1'b1 && rx_data_ready_in) begin
      cnt[WD]++;
      if (rx_first_out === 1'b1) first_byte = rx_data_out;
    end
  end
  // ==========================================================
  // Shared helpers
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic fr(input logic [1:0] t, input logic [1:0] low, input int len, input logic ab);
    cnt = '{default: 0};
    slfc_peer_inst.frame({4'h0, t, low}, len, ab, 1'b1);
    slfc_peer_inst.idle();
  endtask
  // Negative good, drop or ack arguments mean the count is not judged; the erp count is always judged
  task automatic expect_ev(input int g, input int d, input int a, input int e, input logic [1:0] c);
    repeat (3) @(posedge sys_clk_in);
    #1;
    if (g >= 0) `CHK("good", g, cnt[GD])
    if (d >= 0) `CHK("drop", d, cnt[DR])
    if (a >= 0) `CHK("ack", a, cnt[AK])
    `CHK("erp", e, cnt[ER])
    if (e > 0) `CHK("cause", c, cause)
    `CHK("rx_seq", rxs, rx_seq_out)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_allow();
    logic ok;
    tx_frame_req_in = 1'b1;
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 3; m++) begin
        for (int t = 0; t < 4; t++) begin
          ok = (t == 3) ? (s != 0 && m < 2) : (s == 2 && (t == 2 ? m < 2 : m == 1));
          port_state_in = s[1:0];
          port_mode_in = m[1:0];
          tx_frame_type_in = t[1:0];
          repeat (2) @(posedge sys_clk_in);
          #1;
          if (t != 1) `CHK("allow", ok, tx_frame_allow_out)
        end
      end
    end
    tx_frame_req_in = 1'b0;
    port_state_in = SLFC_ST_READY;
    port_mode_in = SLFC_MD_NORMAL;
  endtask
  task automatic t_tx();
    logic [1:0] tt [5] = '{2'h2, 2'h0, 2'h3, 2'h2, 2'h0};
    logic [4:0] ab = 5'b01000;
    logic [1:0] txs = 2'h0;
    for (int i = 0; i < 5; i++) begin
      tx_frame_type_in = tt[i];
      tx_abort_in = ab[i];
      tx_trail_flag_in = 1'b1;
      @(posedge sys_clk_in);
      #1;
      tx_trail_flag_in = 1'b0;
      tx_abort_in = 1'b0;
      if (tt[i] != SLFC_FT_CTRL && !ab[i]) txs = txs + 2'h1;
      repeat (2) @(posedge sys_clk_in);
      #1;
      `CHK("tx_seq", txs, tx_seq_out)
      `CHK("fwd_seq", txs, fwd_seq_out)
    end
  endtask
  task automatic t_rx();
    fr(SLFC_FT_CFG, rxs, 6, 1'b0);
    rxs = rxs + 2'h1;
    expect_ev(1, 0, 1, 0, 2'h0);
    `CHK("fwd", 1, cnt[FW])
    `CHK("words", 6, cnt[WD])
    `CHK("first", 8'h08, first_byte)
    `CHK("type", SLFC_FT_CFG, rx_frame_type_out)
    cnt = '{default: 0};
    for (int i = 0; i < 4; i++) begin
      slfc_peer_inst.frame({4'h0, i[0] ? SLFC_FT_APP : SLFC_FT_CFG, rxs}, 6, 1'b0, i == 0);
      rxs = rxs + 2'h1;
    end
    slfc_peer_inst.idle();
    expect_ev(4, 0, 4, 0, 2'h0);
    fr(SLFC_FT_CFG, rxs + 2'h2, 6, 1'b0);
    expect_ev(0, 1, 0, 1, SLFC_ERR_SEQ);
    fr(SLFC_FT_CFG, rxs, 6, 1'b1);
    expect_ev(0, 1, 0, 0, 2'h0);
  endtask
  task automatic t_proto();
    for (int k = 0; k < 5; k++) begin
      cnt = '{default: 0};
      slfc_peer_inst.put(SLFC_CH_FLAG, 8'h00);
      if (k == 1) slfc_peer_inst.put(SLFC_CH_ABORT, 8'h00);
      if (k == 2 || k == 4) slfc_peer_inst.put(SLFC_CH_ACK, 8'h00);
      if (k == 3) slfc_peer_inst.put(SLFC_CH_RRDY, 8'h00);
      if (k == 4) slfc_peer_inst.put(SLFC_CH_ACK, 8'h00);
      if (k == 1 || k == 4) slfc_peer_inst.put(SLFC_CH_FLAG, 8'h00);
      else slfc_peer_inst.frame({4'h0, SLFC_FT_CFG, rxs}, k == 0 ? 5 : 6, 1'b0, 1'b0);
      slfc_peer_inst.idle();
      expect_ev(0, -1, 0, (k == 2 || k == 3) ? 2 : 1, SLFC_ERR_PROTO);
    end
  endtask
  task automatic t_insert();
    slfc_char_e ins [5] = '{SLFC_CH_ACK, SLFC_CH_ACK, SLFC_CH_FAIR, SLFC_CH_FAIRR, SLFC_CH_USER};
    cnt = '{default: 0};
    repeat (11) slfc_peer_inst.put(SLFC_CH_FLAG, 8'h00);
    foreach (ins[i]) slfc_peer_inst.put(ins[i], 8'h00);
    slfc_peer_inst.put(SLFC_CH_FLAG, 8'h00);
    slfc_peer_inst.put(SLFC_CH_DATA, {4'h0, SLFC_FT_CFG, rxs});
    slfc_peer_inst.put(SLFC_CH_RRDY, 8'h00);
    slfc_peer_inst.put(SLFC_CH_RRDY, 8'h00);
    slfc_peer_inst.frame(8'h41, 5, 1'b0, 1'b0);
    slfc_peer_inst.idle();
    rxs = rxs + 2'h1;
    expect_ev(1, 0, 1, 0, 2'h0);
  endtask
  task automatic t_ctrl();
    for (int r = 0; r < 4; r++) begin
      fr(SLFC_FT_CTRL, r[1:0], 6, 1'b0);
      expect_ev(-1, -1, -1, int'(r == 2), SLFC_ERR_REJECT);
      `CHK("link", r == 0, cnt[RL])
      `CHK("total", r[0], cnt[RT])
      `CHK("abs", r == 3, cnt[RA])
    end
    fr(SLFC_FT_RSVD, rxs, 6, 1'b0);
    expect_ev(0, -1, 0, 1, SLFC_ERR_REJECT);
    fr(SLFC_FT_CTRL, SLFC_RT_LINK, 10, 1'b0);
    expect_ev(-1, -1, -1, 1, SLFC_ERR_PROTO);
    `CHK("link", 0, cnt[RL])
  endtask
  task automatic t_priv();
    port_mode_in = SLFC_MD_PRIV;
    fr(SLFC_FT_APP, rxs, 6, 1'b0);
    expect_ev(0, 1, 0, 0, 2'h0);
    fr(SLFC_FT_CFG, rxs, 6, 1'b0);
    rxs = rxs + 2'h1;
    expect_ev(1, 0, 1, 0, 2'h0);
    port_mode_in = SLFC_MD_NORMAL;
  endtask
  // Consumer stalls through a long frame, then drains the buffer
  task automatic t_fifo();
    rx_data_ready_in = 1'b0;
    fr(SLFC_FT_CFG, rxs, 20, 1'b0);
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("ovf", 1, cnt[OV] > 0)
    rx_data_ready_in = 1'b1;
    repeat (25) @(posedge sys_clk_in);
    #1;
    `CHK("kept", 1, cnt[WD] >= 16)
    `CHK("sum", 20, cnt[WD] + cnt[OV])
    port_state_in = SLFC_ST_DISABLED;
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("tx_clr", 2'h0, tx_seq_out)
    `CHK("rx_clr", 2'h0, rx_seq_out)
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    nrst_in = 1'b0;
    port_state_in = SLFC_ST_READY;
    port_mode_in = SLFC_MD_NORMAL;
    dest_here_in = 1'b1;
    rx_data_ready_in = 1'b1;
    tx_frame_type_in = 2'h0;
    tx_frame_req_in = 1'b0;
    tx_trail_flag_in = 1'b0;
    tx_abort_in = 1'b0;
    rxs = 2'h0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    nrst_in = 1'b1;
    t_allow();
    t_tx();
    t_rx();
    t_proto();
    t_insert();
    t_ctrl();
    t_priv();
    t_fifo();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    err_total++;
    final_report();
  end
endmodule // tb
